// File: common/acs_pkg.sv
// What this block does
// - reference choice from three-bit regulator field
// - conversion clock is system clock over 1..128
// - input sampled for exactly one conversion period
// - settling counted in conversion clocks; the bandgap wait is counted in system clocks
// - writing start bit begins one conversion
// - start bit reads one when result ready
// - twelve inputs: eleven pins plus one internal
// - internal bandgap offers 1.2, 2, 3, 4 volts
// - one channel per conversion, never combined
package acs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_REFCTL   = 8'h04;
  localparam logic [7:0] OFS_MODE     = 8'h08;
  localparam logic [7:0] OFS_RES_HI   = 8'h0c;
  localparam logic [7:0] OFS_RES_LO   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // field positions
  localparam int CTRL_EN_BIT      = 7;
  localparam int CTRL_GO_BIT      = 6;
  localparam int CH_W             = 4;
  localparam int REF_LSB          = 5;
  localparam int REF_W            = 3;
  localparam int BG_LSB           = 3;
  localparam int BG_W             = 2;
  localparam int QUARTER_BIT      = 2;
  localparam int DIV_W            = 3;
  localparam int MODE_SETTLED_BIT = 7;
  localparam int IRQ_DONE_BIT     = 0;
  localparam int IRQ_SETTLED_BIT  = 1;
  localparam int IRQ_W            = 2;
  localparam int RES_W            = 12;
  localparam int NUM_CH           = 12;
  localparam logic [3:0] CH_INTERNAL = 4'hb;
  // reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] REFCTL_RST = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [1:0] MASK_RST   = 2'h0;
  // reference codes
  localparam logic [2:0] REF_SUPPLY  = 3'h0;
  localparam logic [2:0] REF_2V      = 3'h1;
  localparam logic [2:0] REF_3V      = 3'h2;
  localparam logic [2:0] REF_4V      = 3'h3;
  localparam logic [2:0] REF_BANDGAP = 3'h4;
  localparam logic [2:0] REF_EXT_PIN = 3'h5;
  // timing
  localparam int SETTLE_CYCLES   = 200;
  localparam int BG_SETTLE_MS    = 1;
  localparam int CLK_FREQ_KHZ    = 250000;
  localparam int BG_SETTLE_CYC   = BG_SETTLE_MS * CLK_FREQ_KHZ;
  localparam int CONV_PERIOD_NS  = 2000;

  typedef enum logic [1:0] {
    SAR_IDLE   = 2'b00,
    SAR_ALIGN  = 2'b01,
    SAR_SAMPLE = 2'b10,
    SAR_TRIAL  = 2'b11
  } acs_sar_state_t;

  // reserved reference codes fall back to the supply
  function automatic logic [2:0] acs_ref_decode(input logic [2:0] code);
    acs_ref_decode = (code > REF_EXT_PIN) ? REF_SUPPLY : code;
  endfunction : acs_ref_decode

  // codes 12..15 select nothing at all
  function automatic logic [NUM_CH-1:0] acs_ch_onehot(input logic [3:0] ch);
    acs_ch_onehot = (ch < 4'hc) ? (12'h001 << ch) : 12'h000;
  endfunction : acs_ch_onehot
endpackage : acs_pkg

// File: common/acs_conv_if.sv
`timescale 1ns/1ns
interface acs_conv_if;
  logic        tick;
  logic        start;
  logic        enable;
  logic        comp_hi;
  logic        busy;
  logic        done;
  logic        sample;
  logic [11:0] result;
  logic [11:0] dac_code;
  modport ctrl (output tick, start, enable, comp_hi, input busy, done, sample, result, dac_code);
  modport core (input tick, start, enable, comp_hi, output busy, done, sample, result, dac_code);
endinterface : acs_conv_if

// File: logic/acs_clk_div.sv
`timescale 1ns/1ns
module acs_clk_div #(
  parameter int DIV_W = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div_sel,
  output logic                  tick
);
  localparam int CNT_W = (1 << DIV_W) - 1;
  if (DIV_W < 1 || DIV_W > 4) begin : g_bad_width
    $error("acs_clk_div: DIV_W out of range");
  end
  logic [CNT_W-1:0] cnt;
  wire  [CNT_W-1:0] last = CNT_W'((1 << div_sel) - 1);
  wire              wrap = (cnt >= last);
  // one pulse every 2**div_sel system clocks
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= run & wrap;
      cnt  <= (!run || wrap) ? '0 : cnt + 1'b1;
    end
  end
endmodule : acs_clk_div

// File: logic/acs_sar.sv
`timescale 1ns/1ns
module acs_sar #(
  parameter int RES_W = 12
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  acs_conv_if.core  cif
);
  import acs_pkg::*;
  if (RES_W != 12) begin : g_bad_res
    $error("acs_sar: RES_W must match the 12-bit port");
  end
  acs_sar_state_t   state;
  logic [RES_W-1:0] trial;
  wire  [RES_W-1:0] kept = cif.comp_hi ? cif.dac_code : (cif.dac_code & ~trial);
  // one input held for one period, then one trial per period
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= SAR_IDLE;
      trial        <= '0;
      cif.busy     <= 1'b0;
      cif.done     <= 1'b0;
      cif.sample   <= 1'b0;
      cif.result   <= '0;
      cif.dac_code <= '0;
    end else begin
      cif.done <= 1'b0;
      if (!cif.enable) begin
        state      <= SAR_IDLE; // disabling aborts a conversion
        cif.busy   <= 1'b0;
        cif.sample <= 1'b0;
      end else begin
        unique case (state)
          SAR_IDLE: if (cif.start) begin
            state    <= SAR_ALIGN;
            cif.busy <= 1'b1;
          end
          SAR_ALIGN: if (cif.tick) begin
            state      <= SAR_SAMPLE;
            cif.sample <= 1'b1;
          end
          SAR_SAMPLE: if (cif.tick) begin
            state        <= SAR_TRIAL;
            cif.sample   <= 1'b0;
            trial        <= {1'b1, {(RES_W-1){1'b0}}};
            cif.dac_code <= {1'b1, {(RES_W-1){1'b0}}};
          end
          SAR_TRIAL: if (cif.tick) begin
            if (trial[0]) begin
              state        <= SAR_IDLE;
              cif.result   <= kept;
              cif.done     <= 1'b1;
              cif.busy     <= 1'b0;
              cif.dac_code <= '0;
            end else begin
              trial        <= trial >> 1;
              cif.dac_code <= kept | (trial >> 1);
            end
          end
        endcase
      end
    end
  end
endmodule : acs_sar

// File: logic/acs_top.sv
`timescale 1ns/1ns
module acs_top #(
  parameter int BG_SETTLE = acs_pkg::BG_SETTLE_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             irq_o,
  input  wire logic                        comp_hi_i,
  output logic                             conv_en_o,
  output logic      [acs_pkg::NUM_CH-1:0]  ch_sel_o,
  output logic                             int_src_quarter_o,
  output logic      [acs_pkg::BG_W-1:0]    bg_level_o,
  output logic      [acs_pkg::REF_W-1:0]   ref_sel_o,
  output logic                             fast_internal_oscillator_req_o,
  output logic                             sample_o,
  output logic      [acs_pkg::RES_W-1:0]   dac_code_o
);
  import acs_pkg::*;
  localparam int BG_CW = $clog2(BG_SETTLE + 1);
  if (BG_SETTLE < 1) begin : g_bad_settle
    $error("acs_top: BG_SETTLE must be at least one cycle");
  end

  acs_conv_if cif ();

  // register state
  logic             ctrl_en;
  logic [CH_W-1:0]  ctrl_ch;
  logic             done_flag;
  logic [REF_W-1:0] ref_field;
  logic [BG_W-1:0]  bg_lvl;
  logic             quarter;
  logic [DIV_W-1:0] div_sel;
  logic [7:0]       res_hi;
  logic [7:0]       res_lo;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [7:0]       settle_cnt;
  logic [BG_CW-1:0] bg_cnt;
  logic             settled;
  logic             start_q;

  // wishbone decode; one wait state, ack registered
  wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] word_adr = {wb_adr_i[7:2], 2'b00};
  wire       wr       = req & wb_we_i & wb_sel_i[0];
  wire       rd       = req & ~wb_we_i;
  wire [7:0] wd       = wb_dat_i[7:0];
  wire       wr_ctrl  = wr & (word_adr == OFS_CTRL);
  wire       wr_ref   = wr & (word_adr == OFS_REFCTL);
  wire       wr_mode  = wr & (word_adr == OFS_MODE);
  wire       wr_mask  = wr & (word_adr == OFS_IRQ_MASK);
  wire       rd_stat  = rd & (word_adr == OFS_IRQ_STAT);

  // start needs the enable bit in the same write, converter idle
  wire go = wr_ctrl & wd[CTRL_EN_BIT] & wd[CTRL_GO_BIT] & ~cif.busy & ~start_q;
  // busy covers the pending-start cycle too
  wire busy_any  = cif.busy | start_q;
  wire done_read = done_flag & ~busy_any;
  wire [7:0] rd_ctrl = {ctrl_en, done_read, 2'b00, ctrl_ch};
  wire [7:0] rd_ref  = {ref_field, bg_lvl, quarter, 2'b00};
  wire [7:0] rd_mode = {settled, 4'h0, div_sel};
  wire [7:0] rd_byte = (word_adr == OFS_CTRL)     ? rd_ctrl :
                       (word_adr == OFS_REFCTL)   ? rd_ref :
                       (word_adr == OFS_MODE)     ? rd_mode :
                       (word_adr == OFS_RES_HI)   ? res_hi :
                       (word_adr == OFS_RES_LO)   ? res_lo :
                       (word_adr == OFS_IRQ_STAT) ? {6'h00, irq_stat} :
                       (word_adr == OFS_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;

  // settling: any change of enable, channel or source restarts it
  wire ch_changed  = wr_ctrl & (wd[CH_W-1:0] != ctrl_ch);
  wire en_changed  = wr_ctrl & (wd[CTRL_EN_BIT] != ctrl_en);
  wire ref_changed = wr_ref & (wd[7:2] != rd_ref[7:2]);
  wire restart     = ~ctrl_en | ch_changed | en_changed | ref_changed;
  wire ref_is_bg   = (acs_ref_decode(ref_field) >= REF_2V) && (acs_ref_decode(ref_field) <= REF_BANDGAP);
  wire in_is_bg    = (ctrl_ch == CH_INTERNAL) & ~quarter;
  wire bg_used     = ref_is_bg | in_is_bg;
  wire clk_done    = (settle_cnt == 8'(SETTLE_CYCLES));
  wire time_done   = (bg_cnt == BG_CW'(BG_SETTLE));
  wire settled_now = ctrl_en & clk_done & (~bg_used | time_done);
  wire [IRQ_W-1:0] events;
  assign events[IRQ_DONE_BIT]    = cif.done;
  assign events[IRQ_SETTLED_BIT] = settled_now & ~settled;

  // bus answer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // software-written fields; a zero write disables
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_en   <= CTRL_RST[CTRL_EN_BIT];
      ctrl_ch   <= CTRL_RST[CH_W-1:0];
      ref_field <= REFCTL_RST[REF_LSB +: REF_W];
      bg_lvl    <= REFCTL_RST[BG_LSB +: BG_W];
      quarter   <= REFCTL_RST[QUARTER_BIT];
      div_sel   <= MODE_RST[DIV_W-1:0];
      irq_mask  <= MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_en <= wd[CTRL_EN_BIT];
        ctrl_ch <= wd[CH_W-1:0];
      end
      if (wr_ref) begin
        ref_field <= wd[REF_LSB +: REF_W];
        bg_lvl    <= wd[BG_LSB +: BG_W];
        quarter   <= wd[QUARTER_BIT];
      end
      if (wr_mode) div_sel <= wd[DIV_W-1:0];
      if (wr_mask) irq_mask <= wd[IRQ_W-1:0];
    end
  end

  // done flag, results, sticky status; a set beats a clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q   <= 1'b0;
      done_flag <= 1'b0;
      res_hi    <= 8'h00;
      res_lo    <= 8'h00;
      irq_stat  <= '0;
      irq_o     <= 1'b0;
    end else begin
      start_q   <= go;
      done_flag <= cif.done | (done_flag & ~go);
      if (cif.done) begin
        res_hi <= cif.result[RES_W-1:4];
        res_lo <= {cif.result[3:0], 4'h0};
      end
      irq_stat <= events | (rd_stat ? '0 : irq_stat);
      irq_o    <= |(irq_stat & irq_mask);
    end
  end

  // settle counters: clock part counts conversion ticks only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt <= 8'h00;
      bg_cnt     <= '0;
      settled    <= 1'b0;
    end else begin
      if (restart) settle_cnt <= 8'h00;
      else if (cif.tick && !clk_done) settle_cnt <= settle_cnt + 8'h01;
      if (restart) bg_cnt <= '0;
      else if (!time_done) bg_cnt <= bg_cnt + 1'b1;
      settled <= settled_now;
    end
  end

  // analog-facing controls, all registered
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_en_o                      <= 1'b0;
      ch_sel_o                       <= '0;
      int_src_quarter_o              <= 1'b0;
      bg_level_o                     <= '0;
      ref_sel_o                      <= REF_SUPPLY;
      fast_internal_oscillator_req_o <= 1'b0;
    end else begin
      conv_en_o                      <= ctrl_en;
      ch_sel_o                       <= ctrl_en ? acs_ch_onehot(ctrl_ch) : '0;
      int_src_quarter_o              <= quarter;
      bg_level_o                     <= bg_lvl;
      ref_sel_o                      <= acs_ref_decode(ref_field);
      fast_internal_oscillator_req_o <= ctrl_en & ref_is_bg;
    end
  end

  assign cif.enable  = ctrl_en;
  assign cif.start   = start_q;
  assign cif.comp_hi = comp_hi_i;
  assign sample_o    = cif.sample;
  assign dac_code_o  = cif.dac_code;

  acs_clk_div #(
    .DIV_W   (DIV_W)
  ) u_div (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .run     (ctrl_en),
    .div_sel (div_sel),
    .tick    (cif.tick)
  );

  acs_sar #(
    .RES_W   (RES_W)
  ) u_sar (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .cif     (cif.core)
  );

  // helpers: spacing of ticks and length of the sample window
  logic [8:0] tick_gap;
  logic [8:0] samp_len;
  logic       gap_valid;
  wire  [8:0] divisor = 9'(1 << div_sel);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_gap  <= 9'h000;
      samp_len  <= 9'h000;
      gap_valid <= 1'b0;
    end else begin
      tick_gap  <= cif.tick ? 9'h001 : tick_gap + 9'h001;
      gap_valid <= (cif.tick | gap_valid) & ctrl_en & ~wr_mode;
      samp_len  <= sample_o ? samp_len + 9'h001 : 9'h000;
    end
  end

  property p_tick_spacing;
    @(posedge ref_clk) disable iff (!arst_n)
      cif.tick && gap_valid && $stable(div_sel) |-> tick_gap == divisor;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing differs from divisor");

  property p_sample_len;
    @(posedge ref_clk) disable iff (!arst_n)
      $fell(sample_o) && ctrl_en && $stable(div_sel) |-> samp_len == divisor;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample window not one period");

  property p_start_busy;
    @(posedge ref_clk) disable iff (!arst_n)
      go |=> ##1 cif.busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not begin a conversion");

  property p_done_ready;
    @(posedge ref_clk) disable iff (!arst_n)
      cif.done |=> done_read && res_hi == $past(cif.result[RES_W-1:4]);
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("done not shown after conversion");

  property p_left_justify;
    @(posedge ref_clk) disable iff (!arst_n)
      cif.done |=> res_lo == {$past(cif.result[3:0]), 4'h0};
  endproperty
  a_left_justify: assert property (p_left_justify) else $error("low byte not left-justified");

  property p_busy_zero;
    @(posedge ref_clk) disable iff (!arst_n)
      rd && word_adr == OFS_CTRL && busy_any |=> !wb_dat_o[CTRL_GO_BIT];
  endproperty
  a_busy_zero: assert property (p_busy_zero) else $error("start bit reads one while busy");

  property p_zero_disables;
    @(posedge ref_clk) disable iff (!arst_n)
      wr_ctrl && wd == 8'h00 |=> !ctrl_en ##1 !conv_en_o && ch_sel_o == '0;
  endproperty
  a_zero_disables: assert property (p_zero_disables) else $error("zero write did not disable");

  property p_one_channel;
    @(posedge ref_clk) disable iff (!arst_n)
      sample_o |-> $onehot(ch_sel_o);
  endproperty
  a_one_channel: assert property (p_one_channel) else $error("sampling without exactly one channel");

  property p_ref_decode;
    @(posedge ref_clk) disable iff (!arst_n)
      wr_ref |=> ##1 ref_sel_o == acs_ref_decode($past(wd[REF_LSB +: REF_W], 2));
  endproperty
  a_ref_decode: assert property (p_ref_decode) else $error("reference output wrong");

  property p_settle_clocks;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(settled) |-> settle_cnt == 8'(SETTLE_CYCLES) && (!bg_used || time_done);
  endproperty
  a_settle_clocks: assert property (p_settle_clocks) else $error("settled before 200 conversion clocks");
endmodule : acs_top

// File: verif/acs_analog_model.sv
`timescale 1ns/1ns
module acs_analog_model (
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  input  wire logic [11:0]                lvl_base,
  input  wire logic [acs_pkg::NUM_CH-1:0] ch_sel,
  input  wire logic                       quarter,
  input  wire logic [acs_pkg::BG_W-1:0]   bg_level,
  input  wire logic                       sample,
  input  wire logic [acs_pkg::RES_W-1:0]  dac_code,
  output logic                            comp_hi
);
  import acs_pkg::*;
  logic [11:0] level;
  logic [11:0] int_level;
  logic [11:0] held;
  logic        held_ok;
  logic        wander;
  int          nsel;

  // internal source: quarter supply or one of four bandgap levels
  assign int_level = quarter ? 12'h0400 : (12'h0100 + {2'b00, bg_level, 8'h00});

  // one-hot mux; zero or several selections give no usable level
  always_comb begin
    level = 12'h0000;
    nsel  = 0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_sel[i]) begin
        nsel++;
        level = (i == NUM_CH - 1) ? int_level : 12'(lvl_base + 12'(i) * 12'h0155);
      end
    end
  end

  // hold capacitor follows the input only while the sample window is open
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      held    <= 12'h0000;
      held_ok <= 1'b0;
      wander  <= 1'b0;
    end else begin
      wander <= ~wander;
      if (sample) begin
        held    <= level;
        held_ok <= (nsel == 1);
      end
    end
  end

  // a mixed or empty selection wanders so it cannot pass by luck
  assign comp_hi = held_ok ? (held >= dac_code) : wander;
endmodule : acs_analog_model

// File: verif/acs_tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_conversion_sequencer_tb_top;
  import acs_pkg::*;
  localparam int BG_SIM = 1000;
  logic        ref_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, comp_hi_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, irq_o, conv_en_o, int_src_quarter_o, osc_req, sample_o;
  logic [NUM_CH-1:0] ch_sel_o;
  logic [BG_W-1:0]   bg_level_o;
  logic [REF_W-1:0]  ref_sel_o;
  logic [RES_W-1:0]  dac_code_o;
  int num_errors, n_compared, cycles, run_len, last_w;

  acs_top #(.BG_SETTLE(BG_SIM)) u_acs_top (
    .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .comp_hi_i(comp_hi_i), .conv_en_o(conv_en_o),
    .ch_sel_o(ch_sel_o), .int_src_quarter_o(int_src_quarter_o), .bg_level_o(bg_level_o),
    .ref_sel_o(ref_sel_o), .fast_internal_oscillator_req_o(osc_req), .sample_o(sample_o),
    .dac_code_o(dac_code_o));

  acs_analog_model u_acs_analog_model (
    .ref_clk(ref_clk), .arst_n(arst_n), .lvl_base(12'h00a3), .ch_sel(ch_sel_o),
    .quarter(int_src_quarter_o), .bg_level(bg_level_o), .sample(sample_o), .dac_code(dac_code_o),
    .comp_hi(comp_hi_i));

  // 250 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // cycle count for timeout and settling measurement; sample window width
  always @(posedge ref_clk) begin
    cycles++;
    if (sample_o === 1'b1) run_len++;
    else if (run_len != 0) begin
      last_w  = run_len;
      run_len = 0;
    end
    if (cycles == 60000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // classic single wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd, output logic [7:0] rdv);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= 32'(wd);
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rdv = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] dummy;
    wb(1'b1, adr, d, dummy);
  endtask : wr

  task automatic rd(input logic [7:0] adr, output logic [7:0] v);
    wb(1'b0, adr, 8'h00, v);
  endtask : rd

  task automatic wait_settled();
    logic [7:0] v;
    int n;
    n = 0;
    do begin
      rd(OFS_MODE, v);
      n++;
    end while (v[MODE_SETTLED_BIT] !== 1'b1 && n < 3000);
    `CHK(v[MODE_SETTLED_BIT], 1'b1)
  endtask : wait_settled

  // start, poll for done, read high then low byte
  task automatic convert(input logic [3:0] ch, input logic [11:0] expv);
    logic [7:0] v, hi, lo;
    int n;
    wr(OFS_CTRL, 8'hc0 | 8'(ch));
    rd(OFS_CTRL, v);
    `CHK(v[CTRL_GO_BIT], 1'b0)
    n = 0;
    while (v[CTRL_GO_BIT] !== 1'b1 && n < 3000) begin
      rd(OFS_CTRL, v);
      n++;
    end
    `CHK(v[CTRL_GO_BIT], 1'b1)
    rd(OFS_RES_HI, hi);
    rd(OFS_RES_LO, lo);
    `CHK({hi, lo}, {expv, 4'h0})
  endtask : convert

  task automatic t_reset();
    logic [7:0] v;
    rd(OFS_CTRL, v);     `CHK(v, CTRL_RST)
    rd(OFS_REFCTL, v);   `CHK(v, REFCTL_RST)
    rd(OFS_MODE, v);     `CHK(v, MODE_RST)
    rd(OFS_IRQ_MASK, v); `CHK(v[1:0], MASK_RST)
    wr(8'h1c, 8'hff);
    rd(8'h1c, v);        `CHK(v, 8'h00)
    `CHK({conv_en_o, irq_o, ref_sel_o, osc_req}, 6'h00)
  endtask : t_reset

  // every reference code, bandgap level and internal source choice
  task automatic t_refs();
    logic [2:0] exp_ref;
    wr(OFS_CTRL, 8'h80);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_REFCTL, {3'(c), 2'(c), 1'(c), 2'b00});
      repeat (2) @(posedge ref_clk);
      exp_ref = (c > 5) ? REF_SUPPLY : 3'(c);
      `CHK(ref_sel_o, exp_ref)
      `CHK(osc_req, (c >= 1 && c <= 4))
      `CHK({bg_level_o, int_src_quarter_o}, {2'(c), 1'(c)})
    end
    wr(OFS_REFCTL, 8'h00);
  endtask : t_refs

  // settling counted in conversion clocks, restarted on reference change
  task automatic t_settle();
    logic [7:0] v;
    int t0;
    wr(OFS_CTRL, 8'h00);
    wr(OFS_MODE, 8'h01);
    wr(OFS_CTRL, 8'h83);
    t0 = cycles;
    wait_settled();
    `CHK((cycles - t0 >= 395 && cycles - t0 <= 420), 1'b1)
    rd(OFS_IRQ_STAT, v); `CHK(v[IRQ_SETTLED_BIT], 1'b1)
    rd(OFS_IRQ_STAT, v); `CHK(v[1:0], 2'b00)
    wr(OFS_REFCTL, {REF_BANDGAP, 5'h00});
    t0 = cycles;
    rd(OFS_MODE, v);     `CHK(v[MODE_SETTLED_BIT], 1'b0)
    wait_settled();
    `CHK((cycles - t0 >= BG_SIM && cycles - t0 <= BG_SIM + 30), 1'b1)
    wr(OFS_REFCTL, 8'h04);
    wait_settled();
  endtask : t_settle

  // every channel, including the internal quarter-supply source
  task automatic t_channels();
    logic [11:0] ev;
    wr(OFS_MODE, 8'h00);
    for (int ch = 0; ch < NUM_CH; ch++) begin
      wr(OFS_CTRL, 8'h80 | 8'(ch));
      wait_settled();
      `CHK(ch_sel_o, 12'(12'h001 << ch))
      ev = (ch == NUM_CH - 1) ? 12'h0400 : 12'(12'h00a3 + 12'(ch) * 12'h0155);
      convert(4'(ch), ev);
    end
  endtask : t_channels

  // every divider ratio sets a sample window of one conversion clock
  task automatic t_div();
    for (int s = 0; s < 8; s++) begin
      wr(OFS_MODE, 8'(s));
      convert(4'h2, 12'(12'h00a3 + 12'h02aa));
      `CHK(last_w, (1 << s))
    end
  endtask : t_div

  task automatic t_irq();
    logic [7:0] v;
    wr(OFS_MODE, 8'h00);
    rd(OFS_IRQ_STAT, v);
    wr(OFS_IRQ_MASK, 8'h01);
    convert(4'h2, 12'h034d);
    repeat (2) @(posedge ref_clk);
    `CHK(irq_o, 1'b1)
    rd(OFS_IRQ_STAT, v); `CHK(v[IRQ_DONE_BIT], 1'b1)
    repeat (2) @(posedge ref_clk);
    `CHK(irq_o, 1'b0)
    wr(OFS_IRQ_MASK, 8'h00);
    convert(4'h2, 12'h034d);
    repeat (2) @(posedge ref_clk);
    `CHK(irq_o, 1'b0)
    rd(OFS_IRQ_STAT, v); `CHK(v[IRQ_DONE_BIT], 1'b1)
  endtask : t_irq

  // zero write mid-conversion disables and suppresses done
  task automatic t_abort();
    logic [7:0] v;
    wr(OFS_MODE, 8'h07);
    wr(OFS_CTRL, 8'hc2);
    repeat (300) @(posedge ref_clk);
    wr(OFS_CTRL, 8'h00);
    repeat (2) @(posedge ref_clk);
    `CHK(conv_en_o, 1'b0)
    repeat (2000) @(posedge ref_clk);
    rd(OFS_IRQ_STAT, v); `CHK(v[IRQ_DONE_BIT], 1'b0)
    rd(OFS_CTRL, v);     `CHK(v[CTRL_GO_BIT], 1'b0)
  endtask : t_abort

  // main sequence
  initial begin
    arst_n   = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    run_len = 0;
    last_w = 0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_refs();
    t_settle();
    t_channels();
    t_div();
    t_irq();
    t_abort();
    results();
  end
endmodule : adc_conversion_sequencer_tb_top
